// >>> hw/prm_regs.sv
`timescale 1ns/100ps
module prm_regs
  import prm_pkg::*;
(
  input  wire logic                               i_clk_sys,    // 125 MHz system clock
  input  wire logic                               i_por_n,      // power-on reset, sync, active low
  input  wire logic                               i_rst_n,      // reset pin, sync, active low
  input  wire prm_cmd_t                           i_cmd,        // decoded serial command
  input  wire logic [PRM_NCH-1:0]                 i_chan_off,   // channel n in off mode
  output logic [7:0]                              o_rdata,      // read data byte
  output logic                                    o_rvalid,     // read data valid pulse
  output logic                                    o_cmd_hit,    // command code belongs here
  output logic                                    o_ignored,    // remap write discarded pulse
  output logic [7:0]                              o_remap,      // physical code per logical
  output logic [PRM_PRIO_W-1:0]                   o_ch1_prio,   // channel 1 priority
  output logic [PRM_PRIO_W-1:0]                   o_ch2_prio,   // channel 2 priority
  output logic [PRM_NCH-1:0][PRM_NCH-1:0]         o_route       // [physical][logical] select
);

  prm_state_t state_q;
  prm_state_t state_d;
  logic       dup;
  logic       all_off;
  logic       wr_remap;

  ////////////////////////////////////////////////////////////////////////////
  // duplicate code detection over the incoming byte
  always_comb
  begin
    dup = 1'b0;
    for (int i = 0; i < PRM_NCH; i++)
    begin
      for (int j = i + 1; j < PRM_NCH; j++)
      begin
        if (i_cmd.data[PRM_CODE_W*i +: PRM_CODE_W] == i_cmd.data[PRM_CODE_W*j +: PRM_CODE_W])
          dup = 1'b1;
      end
    end
  end

  assign all_off  = &i_chan_off;
  assign wr_remap = i_cmd.wr && (i_cmd.code == PRM_CMD_REMAP);

  ////////////////////////////////////////////////////////////////////////////
  // next state: writes, reads, discard flag and both resets
  always_comb
  begin
    state_d         = state_q;
    state_d.rvalid  = 1'b0;
    state_d.ignored = 1'b0;
    if (wr_remap)
    begin
      // remapping a live channel would move its gate drive mid-power
      if (all_off && !dup)
        state_d.remap = i_cmd.data;
      else
        state_d.ignored = 1'b1;
    end
    if (i_cmd.wr && (i_cmd.code == PRM_CMD_PRIO))
      state_d.prio = i_cmd.data & PRM_PRIO_MASK;
    if (i_cmd.rd)
    begin
      state_d.rvalid = 1'b1;
      case (i_cmd.code)
        PRM_CMD_REMAP: state_d.rdata = state_q.remap;
        PRM_CMD_PRIO:  state_d.rdata = state_q.prio;
        default:       state_d.rdata = PRM_RD_NONE;
      endcase
    end
    // the reset pin clears all but the mapping and drops any command of that cycle
    if (!i_rst_n)
    begin
      state_d.remap   = state_q.remap;
      state_d.prio    = PRM_PRIO_RST;
      state_d.rdata   = PRM_RD_NONE;
      state_d.rvalid  = 1'b0;
      state_d.ignored = 1'b0;
    end
    // of the two resets, only power-on brings the mapping back to identity
    if (!i_por_n)
    begin
      state_d.remap   = PRM_REMAP_RST;
      state_d.prio    = PRM_PRIO_RST;
      state_d.rdata   = PRM_RD_NONE;
      state_d.rvalid  = 1'b0;
      state_d.ignored = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one register stage for the whole state; both resets are folded in above
  always_ff @(posedge i_clk_sys)
  begin
    state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_rdata    = state_q.rdata;
  assign o_rvalid   = state_q.rvalid;
  assign o_ignored  = state_q.ignored;
  assign o_cmd_hit  = (i_cmd.code == PRM_CMD_REMAP) || (i_cmd.code == PRM_CMD_PRIO);
  assign o_remap    = state_q.remap;
  assign o_ch1_prio = state_q.prio[PRM_CH1_LSB +: PRM_PRIO_W];
  assign o_ch2_prio = state_q.prio[PRM_CH2_LSB +: PRM_PRIO_W];

  // pin steering: physical p serves logical l when l's code equals p
  // 4-pair wiring of logical 1-2 / 3-4 is assumed outside
  for (genvar p = 0; p < PRM_NCH; p++)
  begin : g_phys
    for (genvar l = 0; l < PRM_NCH; l++)
    begin : g_log
      assign o_route[p][l] = (state_q.remap[PRM_CODE_W*l +: PRM_CODE_W] == PRM_CODE_W'(p));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  remap_default_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    $past(!i_por_n) |-> (o_remap == PRM_REMAP_RST))
    else $error("remap not at default after power-on");

  remap_keep_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    $past(!i_rst_n) |-> $stable(o_remap))
    else $error("remap changed across reset pin");

  dup_reject_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    (wr_remap && dup) |=> ($stable(o_remap) && o_ignored))
    else $error("duplicate remap write taken");

  off_gate_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    (wr_remap && !all_off) |=> ($stable(o_remap) && o_ignored))
    else $error("remap taken while a channel is on");

  remap_take_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    (wr_remap && all_off && !dup) |=> (o_remap == $past(i_cmd.data)) && !o_ignored)
    else $error("valid remap write lost");

  prio_rsv_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    (i_cmd.rd && i_cmd.code == PRM_CMD_PRIO) |=> (!o_rdata[PRM_RSV_HI] && !o_rdata[PRM_RSV_LO]))
    else $error("unused priority bits read nonzero");

  prio_reset_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    $past(!i_rst_n) |-> (o_ch1_prio == 3'h0 && o_ch2_prio == 3'h0))
    else $error("priority not cleared by reset");

  prio_rw_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    (i_cmd.wr && i_cmd.code == PRM_CMD_PRIO && !i_cmd.rd) ##1 (i_cmd.rd && i_cmd.code == PRM_CMD_PRIO)
      |=> (o_rvalid && o_rdata == ($past(i_cmd.data, 2) & PRM_PRIO_MASK)))
    else $error("priority readback mismatch");

  route_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    (o_route[o_remap[1:0]][0] && $onehot({o_route[3][0], o_route[2][0], o_route[1][0], o_route[0][0]})))
    else $error("logical 1 steering wrong");

  ////////////////////////////////////////////////////////////////////////////
  // answers, holds and resets of the command port
  rvalid_pulse_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    i_cmd.rd |=> o_rvalid)
    else $error("read not answered");

  rvalid_idle_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    !i_cmd.rd |=> !o_rvalid)
    else $error("read valid without a read");

  remap_read_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    (i_cmd.rd && i_cmd.code == PRM_CMD_REMAP) |=> (o_rdata == $past(o_remap)))
    else $error("remap readback wrong");

  other_read_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    (i_cmd.rd && i_cmd.code != PRM_CMD_REMAP && i_cmd.code != PRM_CMD_PRIO) |=> (o_rdata == PRM_RD_NONE))
    else $error("foreign code read nonzero");

  rdata_hold_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    !i_cmd.rd |=> $stable(o_rdata))
    else $error("read data moved without a read");

  // a reset-pin pulse also drops a read in flight; the host has to repeat it
  rd_rst_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    $past(!i_rst_n) |-> (!o_rvalid && !o_ignored && (o_rdata == PRM_RD_NONE)))
    else $error("port outputs not cleared by reset");

  // the mapping moves only on an accepted write
  remap_hold_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    !wr_remap |=> $stable(o_remap))
    else $error("remap moved without a write");

  ignore_cause_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    !wr_remap |=> !o_ignored)
    else $error("discard flag without a remap write");

  // priority bytes: taken as written, held otherwise, zero after power-on
  prio_take_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    (i_cmd.wr && i_cmd.code == PRM_CMD_PRIO)
      |=> ((o_ch1_prio == $past(i_cmd.data[PRM_CH1_LSB +: PRM_PRIO_W]))
        && (o_ch2_prio == $past(i_cmd.data[PRM_CH2_LSB +: PRM_PRIO_W]))))
    else $error("priority write not taken");

  prio_hold_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n || !i_rst_n)
    !(i_cmd.wr && i_cmd.code == PRM_CMD_PRIO) |=> ($stable(o_ch1_prio) && $stable(o_ch2_prio)))
    else $error("priority moved without a write");

  prio_por_a : assert property (@(posedge i_clk_sys)
    $past(!i_por_n) |-> ((o_ch1_prio == PRM_PRIO_RST[PRM_CH1_LSB +: PRM_PRIO_W])
      && (o_ch2_prio == PRM_PRIO_RST[PRM_CH2_LSB +: PRM_PRIO_W])))
    else $error("priority not cleared by power-on");

  // unused bits are masked on the way in, so the stored byte never holds them
  prio_unused_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
    (!state_q.prio[PRM_RSV_HI] && !state_q.prio[PRM_RSV_LO]))
    else $error("unused priority bits stored");

  // every logical channel steers to the physical channel its code names, and no
  // physical channel serves two logical ones because duplicates never land
  for (genvar k = 0; k < PRM_NCH; k++)
  begin : g_route_chk
    route_col_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
      (o_route[o_remap[PRM_CODE_W*k +: PRM_CODE_W]][k]
        && $onehot({o_route[3][k], o_route[2][k], o_route[1][k], o_route[0][k]})))
      else $error("logical channel steering wrong");

    route_row_a : assert property (@(posedge i_clk_sys) disable iff (!i_por_n)
      $onehot(o_route[k]))
      else $error("physical channel shared by two logical channels");
  end

endmodule // prm_regs

// >>> hw/prm_pkg.sv
// Contract
// - code 00..11 selects physical channel 1..4
// - default mapping is logical n to physical n
// - remap survives the reset pin
// - priority register at command 27h, read/write
// - ch2 prio bits 6:4, ch1 bits 2:0, reset zero
// - remap register at command 26h, reset E4h
// - remap accepted only when all four channels off
package prm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes and reset values
  localparam logic [7:0] PRM_CMD_REMAP  = 8'h26;
  localparam logic [7:0] PRM_CMD_PRIO   = 8'h27;
  localparam logic [7:0] PRM_REMAP_RST  = 8'hE4;
  localparam logic [7:0] PRM_PRIO_RST   = 8'h00;
  localparam logic [7:0] PRM_PRIO_MASK  = 8'h77;
  localparam logic [7:0] PRM_RD_NONE    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int         PRM_NCH        = 4;
  localparam int         PRM_CODE_W     = 2;
  localparam int         PRM_CH1_LSB    = 0;
  localparam int         PRM_CH2_LSB    = 4;
  localparam int         PRM_PRIO_W     = 3;
  localparam int         PRM_RSV_LO     = 3;
  localparam int         PRM_RSV_HI     = 7;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic       wr;    // one-cycle write strobe
    logic       rd;    // one-cycle read strobe
    logic [7:0] code;  // command code
    logic [7:0] data;  // write data byte
  } prm_cmd_t;

  typedef struct packed {
    logic [7:0] remap;   // four 2-bit physical codes, logical 4 in top pair
    logic [7:0] prio;    // pair one/two shutdown priority
    logic [7:0] rdata;   // read answer
    logic       rvalid;  // read answer valid
    logic       ignored; // remap write discarded
  } prm_state_t;

endpackage

// >>> testbench/prm_host.sv
`timescale 1ns/100ps
module prm_host
  import prm_pkg::*;
(
  input  wire logic i_clk_sys, // system clock
  output prm_cmd_t  o_cmd      // command toward the block
);
  // one command per call, wr and rd as given, launched just after an edge and dropped one edge later
  task automatic send(input logic w, input logic r, input logic [7:0] c, input logic [7:0] d);
    @(posedge i_clk_sys) #1;
    o_cmd = '{wr: w, rd: r, code: c, data: d};
    @(posedge i_clk_sys) #1;
    o_cmd = '0;
  endtask
  // write then read of one code on back-to-back edges, the tightest legal order
  task automatic send_pair(input logic [7:0] c, input logic [7:0] d);
    @(posedge i_clk_sys) #1;
    o_cmd = '{wr: 1'b1, rd: 1'b0, code: c, data: d};
    @(posedge i_clk_sys) #1;
    o_cmd = '{wr: 1'b0, rd: 1'b1, code: c, data: 8'h00};
    @(posedge i_clk_sys) #1;
    o_cmd = '0;
  endtask
  // no 4-pair wiring is modelled and power-on is never commanded, so the
  // pairing limit and the detect-before-power duty are kept by omission
  initial o_cmd = '0;
endmodule // prm_host

// >>> testbench/test_port_remap_priority_regs.sv
`timescale 1ns/100ps
module test_port_remap_priority_regs;
  import prm_pkg::*;
  logic            i_clk_sys, i_por_n, i_rst_n;
  logic [3:0]      i_chan_off;
  prm_cmd_t        cmd;
  logic [7:0]      o_rdata, o_remap, d;
  logic            o_rvalid, o_ignored, o_cmd_hit;
  logic [2:0]      o_ch1_prio, o_ch2_prio;
  logic [3:0][3:0] o_route;
  logic [7:0]      exp_q[$];
  int              errors = 0;
  int              total_checks = 0;
  int              ign_cnt = 0;
  prm_host host_inst (.i_clk_sys(i_clk_sys), .o_cmd(cmd));
  prm_regs prm_regs_inst (.i_clk_sys(i_clk_sys), .i_por_n(i_por_n), .i_rst_n(i_rst_n), .i_cmd(cmd),
    .i_chan_off(i_chan_off), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_cmd_hit(o_cmd_hit),
    .o_ignored(o_ignored), .o_remap(o_remap), .o_ch1_prio(o_ch1_prio), .o_ch2_prio(o_ch2_prio),
    .o_route(o_route));
  ////////////////////////////////////////////////////////////////////////////
  // shared compare, bus tasks and verdict
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    exp_q.push_back(e); // note goes in before the strobe so the watcher never runs dry
    host_inst.send(1'b0, 1'b1, c, 8'h00);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    host_inst.send(1'b1, 1'b0, c, v);
  endtask
  task automatic close_out();
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock, watchdog and read watcher
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    #100000;
    errors++;
    close_out();
  end
  // sampled before this edge's updates land, so data and valid come from the same cycle
  always @(posedge i_clk_sys)
  begin
    if (o_ignored === 1'b1)
      ign_cnt++;
    if ((cmd.wr || cmd.rd) === 1'b1)
      chk("cmd hit", {7'h00, (cmd.code == PRM_CMD_REMAP) || (cmd.code == PRM_CMD_PRIO)},
        {7'h00, o_cmd_hit});
    if (o_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("spare read", 8'h00, 8'hFF);
      else
        chk("read data", exp_q.pop_front(), o_rdata);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(32'h40F7));
    i_por_n = 1'b0;
    i_rst_n = 1'b0;
    i_chan_off = 4'hF;
    repeat (4) @(posedge i_clk_sys);
    #1 i_por_n = 1'b1;
    i_rst_n = 1'b1;
    rd(PRM_CMD_REMAP, 8'hE4);
    rd(PRM_CMD_PRIO, 8'h00);
    wr(8'h30, 8'h5A);
    rd(8'h30, PRM_RD_NONE);
    wr(PRM_CMD_PRIO, 8'hFF);
    rd(PRM_CMD_PRIO, 8'h77);
    wr(PRM_CMD_REMAP, 8'h1B);
    rd(PRM_CMD_REMAP, 8'h1B);
    chk("route l1 p4", 8'h01, {7'h00, o_route[3][0]});
    wr(PRM_CMD_REMAP, 8'h55);
    rd(PRM_CMD_REMAP, 8'h1B);
    chk("ignored count", 8'h01, 8'(ign_cnt));
    // some channel still on: the remap must be refused
    i_chan_off = 4'($urandom_range(14));
    wr(PRM_CMD_REMAP, 8'hE4);
    rd(PRM_CMD_REMAP, 8'h1B);
    chk("ignored count", 8'h02, 8'(ign_cnt));
    i_chan_off = 4'hF;
    i_rst_n = 1'b0;
    @(posedge i_clk_sys) #1 i_rst_n = 1'b1;
    rd(PRM_CMD_REMAP, 8'h1B);
    chk("remap port", 8'h1B, o_remap);
    rd(PRM_CMD_PRIO, 8'h00);
    repeat (8)
    begin
      d = 8'($urandom);
      wr(PRM_CMD_PRIO, d);
      chk("ch1 prio", {5'h00, d[PRM_CH1_LSB +: PRM_PRIO_W]}, {5'h00, o_ch1_prio});
      chk("ch2 prio", {5'h00, d[PRM_CH2_LSB +: PRM_PRIO_W]}, {5'h00, o_ch2_prio});
      rd(PRM_CMD_PRIO, d & PRM_PRIO_MASK);
      // a read in the same cycle as a write returns the old byte
      exp_q.push_back(d & PRM_PRIO_MASK);
      host_inst.send(1'b1, 1'b1, PRM_CMD_PRIO, ~d);
      d = 8'($urandom);
      exp_q.push_back(d & PRM_PRIO_MASK);
      host_inst.send_pair(PRM_CMD_PRIO, d);
    end
    repeat (3) @(posedge i_clk_sys);
    if (exp_q.size() != 0)
      chk("pending reads", 8'h00, 8'(exp_q.size()));
    close_out();
  end
endmodule // test_port_remap_priority_regs
